// file: common/tdg_map.svh
// register offsets, field positions and reset values of the toggle/dither block
`ifndef TDG_MAP_SVH
`define TDG_MAP_SVH

`define TDG_NCH 16
`define TDG_AB_OFS 8'h00
`define TDG_SWTOG_OFS 8'h04
`define TDG_EN_OFS 8'h08
`define TDG_RUN_OFS 8'h0C
`define TDG_SET_PAGE 2'h1
`define TDG_CODE_PAGE 2'h2
`define TDG_DAC_PAGE 2'h3

`define TDG_PER_LSB 0
`define TDG_SRC_LSB 4
`define TDG_PH_LSB 6
`define TDG_MODE_BIT 8

`define TDG_AB_RST 16'h0000
`define TDG_SWTOG_RST 16'h0000
`define TDG_EN_RST 16'h0000
`define TDG_PER_MAX 3'h4
`define TDG_QUARTER 4'h0
`define TDG_SRC_SW 2'h0

`endif

// file: common/tdg_pkg.sv
// types shared by the toggle/dither controller and its code memory
package tdg_pkg;

  typedef struct packed {
    logic mode;
    logic [1:0] phase;
    logic [1:0] src;
    logic [2:0] per;
  } tdg_set_type;

  typedef struct packed {
    logic [15:0] ab_sel;
    logic [15:0] sw_tog;
    logic [15:0] en;
    logic [15:0] run;
    tdg_set_type [15:0] set;
    logic [15:0][5:0] idx;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] lvl;
    logic [3:0] scan;
    logic [3:0] scan_p;
    logic scan_v;
    logic [15:0][15:0] dac;
    logic ap_v;
    logic ap_w;
    logic [7:0] ap_a;
  } tdg_state_type;

  typedef struct packed {
    logic [15:0][31:0] words;
    logic [31:0] rd0;
    logic [31:0] rd1;
  } tdg_mem_state_type;

endpackage : tdg_pkg

// file: common/tdg_mem_if.sv
// signals between the controller and the A/B code memory
`timescale 1ns/100ps
`default_nettype none
interface tdg_mem_if;
  logic we;
  logic wr_b;
  logic [3:0] waddr;
  logic [15:0] wdata;
  logic [3:0] raddr0;
  logic [3:0] raddr1;
  logic [31:0] rdata0;
  logic [31:0] rdata1;
  modport ctrl (output we, wr_b, waddr, wdata, raddr0, raddr1,
                input rdata0, rdata1);
  modport mem (input we, wr_b, waddr, wdata, raddr0, raddr1,
               output rdata0, rdata1);
endinterface : tdg_mem_if
`default_nettype wire

// file: design/tdg_code_mem.sv
// per-channel A/B input code store, two registered read ports
`timescale 1ns/100ps
`default_nettype none
module tdg_code_mem
  import tdg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  tdg_mem_if.mem m
);
  tdg_mem_state_type s_q;
  tdg_mem_state_type s_d;

  // write-through: a read in the write cycle sees the new half-word
  always_comb begin
    s_d = s_q;
    if (m.we) begin
      if (m.wr_b) begin
        s_d.words[m.waddr][31:16] = m.wdata;
      end else begin
        s_d.words[m.waddr][15:0] = m.wdata;
      end
    end
    s_d.rd0 = s_d.words[m.raddr0];
    s_d.rd1 = s_d.words[m.raddr1];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign m.rdata0 = s_q.rd0;
  assign m.rdata1 = s_q.rd1;
endmodule : tdg_code_mem
`default_nettype wire

// file: design/tdg_ctrl.sv
// toggle and sine dither controller for sixteen converter channels
// Summary of operation
// R01: each channel holds codes A and B; toggle clock picks which is latched
// R02: toggle mode shows A while its clock is high, B while low
// R03: toggle clock per channel from three pins or software bit
// R04: writing zero to the enable register stops toggling everywhere
// R05: toggled output changes on both edges of the selected clock
// R06: dither mode produces sine samples from an internal lookup table
// R07: period field 000..100 gives N of 4..64; quarter table fractions
// R08: clock source, period and initial phase set per channel
// R09: dither output advances one sample per rising clock edge only
// R10: dither output code is A plus B times the sine sample
// R11: host places dither amplitude in upper bits, two low bits zero
// R12: full dither amplitude spans one quarter of output range
// R13: channel shows A until enabled, then follows dither edges
// R14: host uses A/B select bit per channel to steer code writes
// R15: mode 0 selects toggle; source 11 selects third pin
// R16: mode 1 selects dither; source 10 second pin; period 100 is 64
// R17: each enable bit enables its own channel
// R18: source 00 software bit, 01 first, 10 second, 11 third pin
// R19: disabled dither finishes its cycle first; toggle reverts at once
// R20: phase field 00..11 starts at 0, 90, 180 or 270 degrees
// R21: software toggle bit changes when its write frame completes
// R22: other quarters mirrored from table; restart at phase on enable
`include "tdg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tdg_ctrl
  import tdg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [2:0] external_toggle_pin,
  output logic [255:0] dac_code
);
  tdg_state_type s_q;
  tdg_state_type s_d;
  tdg_mem_if mi();

  logic [15:0] sw_rise;
  logic [2:0] pin_rise;
  logic [15:0] chan_lvl;
  logic [15:0] chan_rise;
  logic [15:0] en_rise;
  logic [15:0] dith_code;
  logic bus_wr;

  // quarter-wave magnitudes in 1/32 units, 64-point resolution
  // R07 table
  function automatic logic [5:0] quarter_mag(input logic [4:0] k);
    logic [5:0] v;
    v = 6'h00;
    unique case (k)
      5'h00: v = 6'h00;
      5'h01: v = 6'h03;
      5'h02: v = 6'h06;
      5'h03: v = 6'h09;
      5'h04: v = 6'h0C;
      5'h05: v = 6'h0F;
      5'h06: v = 6'h12;
      5'h07: v = 6'h15;
      5'h08: v = 6'h18;
      5'h09: v = 6'h19;
      5'h0A: v = 6'h1B;
      5'h0B: v = 6'h1C;
      5'h0C: v = 6'h1E;
      5'h0D: v = 6'h1F;
      5'h0E: v = 6'h1F;
      default: v = 6'h20;
    endcase
    return v;
  endfunction : quarter_mag

  // illegal period codes behave as the longest period
  function automatic logic [2:0] legal_per(input logic [2:0] per);
    return (per > `TDG_PER_MAX) ? `TDG_PER_MAX : per;
  endfunction : legal_per

  function automatic logic [5:0] last_idx(input logic [2:0] per);
    return (6'h04 << legal_per(per)) - 6'h01;
  endfunction : last_idx

  // sample n of period N, phase in quarter steps, range -32..32
  // R06 sine
  function automatic logic signed [6:0] sine_sample(input logic [5:0] n,
      input logic [2:0] per, input logic [1:0] ph);
    logic [5:0] pos;
    logic [5:0] mag;
    // R20 phase offset
    pos = (n << (3'h4 - legal_per(per))) + {ph, `TDG_QUARTER};
    // R22 mirror
    if (pos[4]) begin
      mag = quarter_mag(5'h10 - {1'b0, pos[3:0]});
    end else begin
      mag = quarter_mag({1'b0, pos[3:0]});
    end
    return pos[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sine_sample

  // A + amplitude*D/32, clamped to the code range
  // R12 amplitude is the 14-bit field, so a quarter span at most
  function automatic logic [15:0] dither_out(input logic [31:0] ab,
      input logic signed [6:0] d);
    logic signed [23:0] prod;
    logic signed [18:0] sum;
    // two low bits of B are ignored, so a careless host does no harm
    prod = $signed({1'b0, ab[31:18]}) * d;
    sum = $signed({3'b000, ab[15:0]}) + 19'(prod >>> 5);
    if (sum < 0) begin
      return 16'h0000;
    end else if (sum > 19'sh0FFFF) begin
      return 16'hFFFF;
    end
    return sum[15:0];
  endfunction : dither_out

  tdg_code_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .m(mi.mem)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign dac_code = s_q.dac;
  assign bus_wr = s_q.ap_v && s_q.ap_w;

  // code writes land in A or B per the select bit of the channel
  // R14 steer writes
  assign mi.we = bus_wr && (s_q.ap_a[7:6] == `TDG_CODE_PAGE);
  assign mi.wr_b = s_q.ab_sel[s_q.ap_a[5:2]];
  assign mi.waddr = s_q.ap_a[5:2];
  assign mi.wdata = hwdata[15:0];
  assign mi.raddr0 = s_q.scan;
  assign mi.raddr1 = haddr[5:2];

  always_comb begin
    hrdata = 32'h0000_0000;
    if (s_q.ap_v && !s_q.ap_w) begin
      unique case (s_q.ap_a[7:6])
        2'h0: begin
          case (s_q.ap_a)
            `TDG_AB_OFS: hrdata = {16'h0000, s_q.ab_sel};
            `TDG_SWTOG_OFS: hrdata = {16'h0000, s_q.sw_tog};
            `TDG_EN_OFS: hrdata = {16'h0000, s_q.en};
            `TDG_RUN_OFS: hrdata = {16'h0000, s_q.run};
            default: hrdata = 32'h0000_0000;
          endcase
        end
        `TDG_SET_PAGE: hrdata = {23'h000000, s_q.set[s_q.ap_a[5:2]].mode,
            s_q.set[s_q.ap_a[5:2]].phase, s_q.set[s_q.ap_a[5:2]].src,
            1'b0, s_q.set[s_q.ap_a[5:2]].per};
        `TDG_CODE_PAGE: hrdata = s_q.ab_sel[s_q.ap_a[5:2]] ?
            {16'h0000, mi.rdata1[31:16]} : {16'h0000, mi.rdata1[15:0]};
        `TDG_DAC_PAGE: hrdata = {16'h0000, s_q.dac[s_q.ap_a[5:2]]};
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    // address phase capture; the slave never stalls
    s_d.ap_v = hsel && hready && htrans[1];
    s_d.ap_w = hwrite;
    s_d.ap_a = haddr[7:0];
    if (bus_wr) begin
      case (s_q.ap_a[7:6])
        2'h0: begin
          case (s_q.ap_a)
            `TDG_AB_OFS: s_d.ab_sel = hwdata[15:0];
            // R21 commit at frame end
            `TDG_SWTOG_OFS: s_d.sw_tog = hwdata[15:0];
            // R04 all-zero disables
            `TDG_EN_OFS: s_d.en = hwdata[15:0];
            default: s_d.en = s_q.en;
          endcase
        end
        // R08 per-channel settings
        `TDG_SET_PAGE: begin
          s_d.set[s_q.ap_a[5:2]].per = hwdata[`TDG_PER_LSB +: 3];
          s_d.set[s_q.ap_a[5:2]].src = hwdata[`TDG_SRC_LSB +: 2];
          s_d.set[s_q.ap_a[5:2]].phase = hwdata[`TDG_PH_LSB +: 2];
          s_d.set[s_q.ap_a[5:2]].mode = hwdata[`TDG_MODE_BIT];
        end
        default: s_d.en = s_q.en;
      endcase
    end
    sw_rise = s_d.sw_tog & ~s_q.sw_tog;
    en_rise = s_d.en & ~s_q.en;

    // pins: three stages, a level counts once stages two and three agree
    s_d.s1 = external_toggle_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int p = 0; p < 3; p++) begin
      if (s_q.s2[p] == s_q.s3[p]) begin
        s_d.lvl[p] = s_q.s3[p];
      end
    end
    pin_rise = s_d.lvl & ~s_q.lvl;

    for (int c = 0; c < `TDG_NCH; c++) begin
      // R03 R18 source mux
      if (s_q.set[c].src == `TDG_SRC_SW) begin
        chan_lvl[c] = s_q.sw_tog[c];
        chan_rise[c] = sw_rise[c];
      end else begin
        chan_lvl[c] = s_q.lvl[s_q.set[c].src - 2'h1];
        chan_rise[c] = pin_rise[s_q.set[c].src - 2'h1];
      end
      // R22 restart on enable
      if (en_rise[c] || !s_q.set[c].mode) begin
        s_d.run[c] = 1'b0;
        s_d.idx[c] = 6'h00;
      end else if (chan_rise[c]) begin
        // R09 R13 advance on rising edges once enabled
        if (!s_q.run[c]) begin
          s_d.run[c] = s_q.en[c];
          s_d.idx[c] = 6'h00;
        end else if (s_q.idx[c] == last_idx(s_q.set[c].per)) begin
          // R19 stop only at the end of a cycle
          s_d.idx[c] = 6'h00;
          s_d.run[c] = s_q.en[c];
        end else begin
          s_d.idx[c] = s_q.idx[c] + 6'h01;
        end
      end
    end

    // round robin: one channel's codes per cycle from the memory
    s_d.scan = s_q.scan + 4'h1;
    s_d.scan_p = s_q.scan;
    s_d.scan_v = 1'b1;
    dith_code = dither_out(mi.rdata0, sine_sample(s_q.idx[s_q.scan_p],
        s_q.set[s_q.scan_p].per, s_q.set[s_q.scan_p].phase));
    if (s_q.scan_v) begin
      // R16 R10 dither path
      if (s_q.set[s_q.scan_p].mode && s_q.run[s_q.scan_p]) begin
        s_d.dac[s_q.scan_p] = dith_code;
      // R15 R17 R01 R02 R05 toggle path
      end else if (!s_q.set[s_q.scan_p].mode && s_q.en[s_q.scan_p]) begin
        s_d.dac[s_q.scan_p] = chan_lvl[s_q.scan_p] ?
            mi.rdata0[15:0] : mi.rdata0[31:16];
      end else begin
        // R13 R19 idle channels show A
        s_d.dac[s_q.scan_p] = mi.rdata0[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ab_sel <= `TDG_AB_RST;
      s_q.sw_tog <= `TDG_SWTOG_RST;
      s_q.en <= `TDG_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  a_toggle_high_a: assert property ( // R02
      @(posedge hclk) disable iff (!hresetn)
      s_q.scan_v && s_q.en[s_q.scan_p] && !s_q.set[s_q.scan_p].mode
      && chan_lvl[s_q.scan_p]
      |=> s_q.dac[$past(s_q.scan_p)] == $past(mi.rdata0[15:0]))
    else $error("toggle high did not show code A");

  a_toggle_low_b: assert property ( // R01
      @(posedge hclk) disable iff (!hresetn)
      s_q.scan_v && s_q.en[s_q.scan_p] && !s_q.set[s_q.scan_p].mode
      && !chan_lvl[s_q.scan_p]
      |=> s_q.dac[$past(s_q.scan_p)] == $past(mi.rdata0[31:16]))
    else $error("toggle low did not show code B");

  a_idle_shows_a: assert property ( // R13
      @(posedge hclk) disable iff (!hresetn)
      s_q.scan_v && !s_q.en[s_q.scan_p] && !s_q.run[s_q.scan_p]
      |=> s_q.dac[$past(s_q.scan_p)] == $past(mi.rdata0[15:0]))
    else $error("disabled channel not at code A");

  a_dither_sum: assert property ( // R10
      @(posedge hclk) disable iff (!hresetn)
      s_q.scan_v && s_q.run[s_q.scan_p] && s_q.set[s_q.scan_p].mode
      |=> s_q.dac[$past(s_q.scan_p)] == $past(dith_code))
    else $error("dither output not A plus B times sample");

  a_step_on_rise: assert property ( // R09
      @(posedge hclk) disable iff (!hresetn)
      s_q.idx[0] != $past(s_q.idx[0])
      |-> $past(chan_rise[0]) || $past(en_rise[0])
      || !$past(s_q.set[0].mode))
    else $error("sample index moved without a rising edge");

  a_stop_at_wrap: assert property ( // R19
      @(posedge hclk) disable iff (!hresetn)
      $fell(s_q.run[0]) && $past(s_q.set[0].mode) && !$past(en_rise[0])
      |-> s_q.idx[0] == 6'h00 && !$past(s_q.en[0]))
    else $error("dither stopped before finishing its cycle");

  a_enable_restart: assert property ( // R22
      @(posedge hclk) disable iff (!hresetn)
      en_rise[0] |=> s_q.idx[0] == 6'h00 && !s_q.run[0]
      ##1 (!s_q.run[0] || $past(chan_rise[0])))
    else $error("enable did not restart at phase start");

  a_swtog_commit: assert property ( // R21
      @(posedge hclk) disable iff (!hresetn)
      s_q.sw_tog != $past(s_q.sw_tog)
      |-> $past(bus_wr && s_q.ap_a == `TDG_SWTOG_OFS))
    else $error("software toggle bit changed without a write");

  a_quarter_table: assert property ( // R07
      @(posedge hclk) disable iff (!hresetn)
      sine_sample(6'h01, 3'h4, 2'h0) == 7'sd3
      && sine_sample(6'h01, 3'h0, 2'h0) == 7'sd32
      && sine_sample(6'h00, 3'h2, 2'h2) == 7'sd0
      && sine_sample(6'h00, 3'h2, 2'h1) == 7'sd32)
    else $error("sine table entry wrong");
endmodule : tdg_ctrl
`default_nettype wire

// file: sim/tdg_pin_drv.sv
// toggle pin source model for the three external clock pins
`timescale 1ns/100ps
`default_nettype none
module tdg_pin_drv (
  input wire logic hclk,
  input wire logic [2:0] level_req,
  output logic [2:0] pins
);
  initial pins = 3'h0;
  // a request reaches the pins one clock after it is made
  always @(posedge hclk) begin
    pins <= level_req;
  end
endmodule : tdg_pin_drv
`default_nettype wire

// file: sim/dac_toggle_dither_generator_tb.sv
// self-checking bench for the toggle/dither controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module dac_toggle_dither_generator_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize, pin_req, pins;
  logic [255:0] dac_code;
  logic [15:0] a0, b0, a1, b1;
  int errors = 0;
  int tests_run = 0;
  int seed;
  int nn;
  int ph0;
  int tbl [17] = '{0, 3, 6, 9, 12, 15, 18, 21, 24, 25, 27, 28, 30, 31, 31,
                   32, 32};
  assign hready = hreadyout;
  tdg_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_toggle_pin(pins), .dac_code(dac_code));
  tdg_pin_drv src (.hclk(hclk), .level_req(pin_req), .pins(pins));

  task report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [15:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(nm, {16'h0000, e}, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask : rchk

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt

  // unselected pins always sit at the opposite level
  task automatic lvl(input int s, input logic l);
    if (s == 0) begin
      xfer(1'b1, 8'h04, {31'h00000000, l});
      pin_req <= {3{~l}};
    end else begin
      pin_req <= l ? (3'h1 << (s - 1)) : ~(3'h1 << (s - 1));
    end
    wt(24);
  endtask : lvl

  function automatic logic [15:0] ch(input int c);
    return dac_code[c * 16 +: 16];
  endfunction : ch

  function automatic logic [15:0] dith(input logic [15:0] a, b,
                                       input int p, ph, n);
    int m, j, v;
    m = 4 << p;
    j = ((n + ph * m / 4) % m) * (64 / m);
    v = ((j / 16) % 2) ? tbl[16 - j % 16] : tbl[j % 16];
    if (j >= 32) v = -v;
    // only the 14-bit amplitude above the two zero bits scales
    v = int'(a) + ((int'(b >> 2) * v) >>> 5);
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return v[15:0];
  endfunction : dith

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    #4000000;
    errors++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    pin_req = 3'h0;
    seed = 32'hcc5b5370;
    a0 = 16'h2000;
    b0 = 16'h1FFF;
    rnd = $random(seed);
    a1 = rnd[15:0];
    rnd = $random(seed);
    // amplitude in upper bits, two low bits zero
    b1 = {rnd[13:0], 2'h0};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ab_sel", 8'h00, 16'h0000);
    rchk("sw_tog", 8'h04, 16'h0000);
    rchk("enable", 8'h08, 16'h0000);
    rchk("settings", 8'h54, 16'h0000);
    xfer(1'b1, 8'h30, 32'h0000FFFF);
    rchk("unmapped", 8'h30, 16'h0000);
    // steer code writes to A, then to B
    xfer(1'b1, 8'h00, 32'h00000000);
    xfer(1'b1, 8'h80, {16'h0000, a0});
    xfer(1'b1, 8'h84, {16'h0000, a1});
    xfer(1'b1, 8'h00, 32'h00000003);
    xfer(1'b1, 8'h80, {16'h0000, b0});
    xfer(1'b1, 8'h84, {16'h0000, b1});
    rchk("code b", 8'h84, b1);
    xfer(1'b1, 8'h00, 32'h00000000);
    rchk("code a", 8'h84, a1);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 8'h40, 32'(s << 4));
      lvl(s, 1'b0);
      `CHK("before enable", a0, ch(0))
      xfer(1'b1, 8'h08, 32'h00000001);
      wt(24);
      `CHK("toggle low", b0, ch(0))
      lvl(s, 1'b1);
      `CHK("toggle high", a0, ch(0))
      lvl(s, 1'b0);
      `CHK("toggle fall", b0, ch(0))
      rchk("settings back", 8'h40, 16'(s << 4));
      xfer(1'b1, 8'h08, 32'h00000000);
      wt(24);
      `CHK("toggle off", a0, ch(0))
    end
    pin_req <= 3'h0;
    // corner: widest amplitude on channel 0, so the low swing clamps
    xfer(1'b1, 8'h00, 32'h00000001);
    xfer(1'b1, 8'h80, 32'h0000FFFC);
    xfer(1'b1, 8'h00, 32'h00000000);
    wt(24);
    for (int p = 0; p < 5; p++) begin
      nn = 4 << p;
      // channel 0 runs half a period away from channel 1
      ph0 = (p + 2) % 4;
      xfer(1'b1, 8'h40, 32'h120 | (ph0 << 6) | p);
      xfer(1'b1, 8'h44, 32'h120 | ((p % 4) << 6) | p);
      rchk("dither set", 8'h44, 16'(32'h120 | ((p % 4) << 6) | p));
      xfer(1'b1, 8'h08, 32'h00000003);
      wt(24);
      `CHK("dither idle", a1, ch(1))
      `CHK("dither idle 0", a0, ch(0))
      // disable after one cycle; the second cycle must still complete
      for (int n = 0; n < 2 * nn; n++) begin
        pin_req <= 3'h2;
        wt(26);
        `CHK("dither sample", dith(a1, b1, p, p % 4, n), ch(1))
        `CHK("dither wide", dith(a0, 16'hFFFC, p, ph0, n), ch(0))
        if (n == 0) begin
          rchk("running", 8'h0C, 16'h0003);
          rchk("out read", 8'hC4, dith(a1, b1, p, p % 4, 0));
        end
        pin_req <= 3'h0;
        wt(26);
        if (n == nn) xfer(1'b1, 8'h08, 32'h00000000);
      end
      pin_req <= 3'h2;
      wt(26);
      `CHK("dither done", a1, ch(1))
      `CHK("dither done 0", a0, ch(0))
      rchk("stopped", 8'h0C, 16'h0000);
      pin_req <= 3'h0;
      wt(26);
    end
    report_and_stop();
  end
endmodule : dac_toggle_dither_generator_tb
`default_nettype wire
